// ### core/gpm_top.sv
// Top: two GPIO ports with the second port's low pins shared with the serial channel
`timescale 1ns/10ps
module gpm_top #(
  parameter int W = gpm_pkg::PORT_W
) (
  input  wire logic                        clk_i,
  input  wire logic                        reset_n_i,
  // First port
  input  wire logic [W-1:0]                portb_pin_i,
  output logic      [W-1:0]                portb_pin_o,
  output logic      [W-1:0]                portb_pin_oe_o,
  input  wire logic [W-1:0]                portb_dir_i,
  input  wire logic [W-1:0]                portb_data_i,
  input  wire gpm_pkg::gpm_drive_t [W-1:0] portb_drive_i,
  input  wire logic [W-1:0]                portb_int_en_i,
  input  wire logic [W-1:0]                portb_int_rise_i,
  input  wire logic [W-1:0]                portb_int_clr_i,
  output logic      [W-1:0]                portb_level_o,
  output logic      [W-1:0]                portb_int_flag_o,
  // Second port
  input  wire logic [W-1:0]                portc_pin_i,
  output logic      [W-1:0]                portc_pin_o,
  output logic      [W-1:0]                portc_pin_oe_o,
  input  wire logic [W-1:0]                portc_dir_i,
  input  wire logic [W-1:0]                portc_data_i,
  input  wire gpm_pkg::gpm_drive_t [W-1:0] portc_drive_i,
  input  wire logic [W-1:0]                portc_int_en_i,
  input  wire logic [W-1:0]                portc_int_rise_i,
  input  wire logic [W-1:0]                portc_int_clr_i,
  output logic      [W-1:0]                portc_level_o,
  output logic      [W-1:0]                portc_int_flag_o,
  // Serial channel selection
  input  wire logic [2:0]                  portc_alt_sel_i,
  input  wire gpm_pkg::gpm_ser_mode_t      serial_mode_i,
  input  wire logic                        spi_master_i,
  // Serial engine side
  input  wire logic                        uart_transmit_line_i,
  output logic                             uart_receive_line_o,
  input  wire logic                        uart_request_to_send_n_i,
  input  wire logic                        spi_slave_out_line_i,
  output logic                             spi_slave_out_line_o,
  input  wire logic                        spi_master_out_line_i,
  output logic                             spi_master_out_line_o,
  input  wire logic                        spi_clock_line_i,
  output logic                             spi_clock_line_o,
  input  wire logic                        i2c_clock_line_low_i,
  output logic                             i2c_clock_line_o,
  input  wire logic                        i2c_data_line_low_i,
  output logic                             i2c_data_line_o
);

  ////////////////////////////////////////////////////////////////////////////
  // GPIO ports

  gpm_port_if #(.W(W)) b_if ();
  gpm_port_if #(.W(W)) c_if ();

  assign b_if.dir      = portb_dir_i;
  assign b_if.data_out = portb_data_i;
  assign b_if.drive    = portb_drive_i;
  assign b_if.int_en   = portb_int_en_i;
  assign b_if.int_rise = portb_int_rise_i;
  assign b_if.int_clr  = portb_int_clr_i;
  assign b_if.pin_raw  = portb_pin_i;

  assign c_if.dir      = portc_dir_i;
  assign c_if.data_out = portc_data_i;
  assign c_if.drive    = portc_drive_i;
  assign c_if.int_en   = portc_int_en_i;
  assign c_if.int_rise = portc_int_rise_i;
  assign c_if.int_clr  = portc_int_clr_i;
  assign c_if.pin_raw  = portc_pin_i;

  gpm_port #(.W(W)) u_portb (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .pif       (b_if.port)
  );

  gpm_port #(.W(W)) u_portc (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .pif       (c_if.port)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Serial pin mux on the shared pins

  typedef struct packed {
    logic [gpm_pkg::SER_PINS-1:0] out;
    logic [gpm_pkg::SER_PINS-1:0] oe;
  } gpm_mux_state_t;

  gpm_mux_state_t st_reg;
  gpm_mux_state_t st_next;

  // Serial outputs are registered here, so shared pins lag the engine by one cycle
  always_comb begin
    logic [1:0] d [gpm_pkg::SER_PINS];
    logic [1:0] gp;
    gp      = 2'b00;
    d       = '{default: 2'b00};
    st_next = '0;
    for (int i = 0; i < gpm_pkg::SER_PINS; i++) begin
      gp   = {c_if.pin_o[i], c_if.pin_oe[i]};
      d[i] = gp;
      if (portc_alt_sel_i[i]) begin
        case (serial_mode_i)
          gpm_pkg::GPM_SER_UART: begin
            case (i)
              gpm_pkg::PIN_SER0: d[i] = gpm_pkg::drive_pin(1'b1, uart_transmit_line_i,
                                                            gpm_pkg::GPM_DRV_PUSH);
              gpm_pkg::PIN_SER1: d[i] = 2'b00;
              default:           d[i] = gpm_pkg::drive_pin(1'b1, uart_request_to_send_n_i,
                                                            gpm_pkg::GPM_DRV_PUSH);
            endcase
          end
          gpm_pkg::GPM_SER_SPI: begin
            case (i)
              gpm_pkg::PIN_SER0: d[i] = gpm_pkg::drive_pin(~spi_master_i, spi_slave_out_line_i,
                                                            gpm_pkg::GPM_DRV_PUSH);
              gpm_pkg::PIN_SER1: d[i] = gpm_pkg::drive_pin(spi_master_i, spi_master_out_line_i,
                                                            gpm_pkg::GPM_DRV_PUSH);
              default:           d[i] = gpm_pkg::drive_pin(spi_master_i, spi_clock_line_i,
                                                            gpm_pkg::GPM_DRV_PUSH);
            endcase
          end
          gpm_pkg::GPM_SER_I2C: begin
            // Both I2C lines only ever pull low; the board pull-up gives the high level
            case (i)
              gpm_pkg::PIN_SER0: d[i] = {1'b0, i2c_clock_line_low_i};
              gpm_pkg::PIN_SER1: d[i] = {1'b0, i2c_data_line_low_i};
              default:           d[i] = gp;
            endcase
          end
          default: d[i] = gp;
        endcase
      end
      st_next.out[i] = d[i][1];
      st_next.oe[i]  = d[i][0];
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_reg.out <= gpm_pkg::SER_RST;
      st_reg.oe  <= gpm_pkg::SER_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign portb_pin_o      = b_if.pin_o;
  assign portb_pin_oe_o   = b_if.pin_oe;
  assign portb_level_o    = b_if.level;
  assign portb_int_flag_o = b_if.int_flag;

  assign portc_pin_o      = {c_if.pin_o[W-1:gpm_pkg::SER_PINS], st_reg.out};
  assign portc_pin_oe_o   = {c_if.pin_oe[W-1:gpm_pkg::SER_PINS], st_reg.oe};
  assign portc_level_o    = c_if.level;
  assign portc_int_flag_o = c_if.int_flag;

  // Serial inputs read the synchronised levels, never the raw pins
  assign uart_receive_line_o   = c_if.level[gpm_pkg::PIN_SER1];
  assign spi_slave_out_line_o  = c_if.level[gpm_pkg::PIN_SER0];
  assign spi_master_out_line_o = c_if.level[gpm_pkg::PIN_SER1];
  assign spi_clock_line_o      = c_if.level[gpm_pkg::PIN_SER2];
  assign i2c_clock_line_o      = c_if.level[gpm_pkg::PIN_SER0];
  assign i2c_data_line_o       = c_if.level[gpm_pkg::PIN_SER1];

endmodule

// ### core/gpm_pkg.sv
// Package of constants, types and helpers for the two-port GPIO and serial pin mux
// Function
// - Each pin of both ports is set to input or output on its own.
// - Any single pin can raise an interrupt on its own, whatever its neighbours do.
// - An output pin can be driven push-pull, open-drain or open-source, chosen per pin.
// - Each low pin of the second port selects either its GPIO function or the serial channel.
// - Shared pin zero is the SPI slave-out line: input as master, output as slave.
// - Shared pin one is the SPI master-out line: output as master, input as slave.
// - Shared pin two is the SPI clock: output as master, input as slave.
// - In UART mode pin zero carries transmit data out and pin one brings receive data in.
// - In UART mode pin two carries the active-low request-to-send output.
// - In I2C mode pin zero is the two-way I2C clock and pin one the two-way I2C data line.
package gpm_pkg;

  localparam int PORT_W = 8;
  localparam int SER_PINS = 3;

  // Shared pin positions on the second port
  localparam int PIN_SER0 = 0;
  localparam int PIN_SER1 = 1;
  localparam int PIN_SER2 = 2;

  // Reset values
  localparam logic [PORT_W-1:0]   PORT_RST = 8'h00;
  localparam logic [SER_PINS-1:0] SER_RST  = 3'h0;

  typedef enum logic [1:0] {
    GPM_DRV_PUSH   = 2'b00,
    GPM_DRV_DRAIN  = 2'b01,
    GPM_DRV_SOURCE = 2'b10
  } gpm_drive_t;

  typedef enum logic [1:0] {
    GPM_SER_UART = 2'b00,
    GPM_SER_SPI  = 2'b01,
    GPM_SER_I2C  = 2'b10,
    GPM_SER_OFF  = 2'b11
  } gpm_ser_mode_t;

  // Returns {pin_out, pin_oe} for one pin
  function automatic logic [1:0] drive_pin(input logic       dir,
                                           input logic       data,
                                           input gpm_drive_t mode);
    logic [1:0] r;
    r = 2'b00;
    case (mode)
      GPM_DRV_DRAIN:  r = {1'b0, dir & ~data};
      GPM_DRV_SOURCE: r = {1'b1, dir & data};
      default:        r = {data, dir};
    endcase
    return r;
  endfunction

endpackage

// ### core/gpm_port_if.sv
// Interface carrying one GPIO port's configuration and state between top and port logic
`timescale 1ns/10ps
interface gpm_port_if #(parameter int W = gpm_pkg::PORT_W);
  logic [W-1:0]                dir;
  logic [W-1:0]                data_out;
  gpm_pkg::gpm_drive_t [W-1:0] drive;
  logic [W-1:0]                int_en;
  logic [W-1:0]                int_rise;
  logic [W-1:0]                int_clr;
  logic [W-1:0]                pin_raw;
  logic [W-1:0]                level;
  logic [W-1:0]                pin_o;
  logic [W-1:0]                pin_oe;
  logic [W-1:0]                int_flag;

  modport ctrl (output dir, data_out, drive, int_en, int_rise, int_clr, pin_raw,
                input  level, pin_o, pin_oe, int_flag);
  modport port (input  dir, data_out, drive, int_en, int_rise, int_clr, pin_raw,
                output level, pin_o, pin_oe, int_flag);
endinterface

// ### core/gpm_port.sv
// One GPIO port: input synchroniser, per-pin drive, per-pin edge interrupt flags
`timescale 1ns/10ps
module gpm_port #(
  parameter int W = gpm_pkg::PORT_W
) (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  gpm_port_if.port  pif
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
    logic [W-1:0] prev;
    logic [W-1:0] flag;
    logic [W-1:0] out;
    logic [W-1:0] oe;
  } gpm_port_state_t;

  gpm_port_state_t st_reg;
  gpm_port_state_t st_next;

  always_comb begin
    logic       hit;
    logic [1:0] drv;
    hit = 1'b0;
    drv = 2'b00;
    st_next      = st_reg;
    st_next.meta = pif.pin_raw;
    st_next.sync = st_reg.meta;
    st_next.prev = st_reg.sync;
    for (int i = 0; i < W; i++) begin
      hit = pif.int_rise[i] ? (st_reg.sync[i] & ~st_reg.prev[i])
                            : (~st_reg.sync[i] & st_reg.prev[i]);
      // Set is applied after clear so a same-cycle edge is never lost
      if (pif.int_clr[i]) begin
        st_next.flag[i] = 1'b0;
      end
      if (pif.int_en[i] && hit) begin
        st_next.flag[i] = 1'b1;
      end
      drv = gpm_pkg::drive_pin(pif.dir[i], pif.data_out[i], pif.drive[i]);
      st_next.out[i] = drv[1];
      st_next.oe[i]  = drv[0];
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pif.level    = st_reg.sync;
  assign pif.pin_o    = st_reg.out;
  assign pif.pin_oe   = st_reg.oe;
  assign pif.int_flag = st_reg.flag;

endmodule

// ### bench/gpm_board.sv
// Board model: pads resolved from device drive, outside drivers and pull-ups
`timescale 1ns/10ps
module gpm_board (
  input  wire logic [7:0] dev_val_i,
  input  wire logic [7:0] dev_en_i,
  input  wire logic [7:0] ext_en_i,
  input  wire logic [7:0] ext_val_i,
  output logic      [7:0] pad_o
);
  // Pull-up on every pad, so a released I2C line reads high
  assign pad_o = (dev_en_i & dev_val_i) | (~dev_en_i & (~ext_en_i | ext_val_i));
endmodule

// ### bench/gpm_top_sva.sv
// Checker on the pin mux top ports
`timescale 1ns/10ps
module gpm_top_sva #(
  parameter int W = gpm_pkg::PORT_W
) (
  input wire logic                   clk_i,
  input wire logic                   reset_n_i,
  input wire logic [W-1:0]           portb_pin_i,
  input wire logic [W-1:0]           portb_pin_oe_o,
  input wire logic [W-1:0]           portb_dir_i,
  input wire logic [W-1:0]           portb_int_en_i,
  input wire logic [W-1:0]           portb_int_rise_i,
  input wire logic [W-1:0]           portb_int_clr_i,
  input wire logic [W-1:0]           portb_level_o,
  input wire logic [W-1:0]           portb_int_flag_o,
  input wire logic [W-1:0]           portc_pin_i,
  input wire logic [W-1:0]           portc_pin_o,
  input wire logic [W-1:0]           portc_pin_oe_o,
  input wire logic [W-1:0]           portc_level_o,
  input wire logic [2:0]             portc_alt_sel_i,
  input wire gpm_pkg::gpm_ser_mode_t serial_mode_i,
  input wire logic                   uart_transmit_line_i,
  input wire logic                   i2c_clock_line_low_i,
  input wire logic                   uart_receive_line_o
);
  logic [1:0]   age_reg;
  logic [W-1:0] lvl_reg;
  logic [W-1:0] evt;
  // Age gates checks whose history still reaches into reset
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      age_reg <= 2'h0;
      lvl_reg <= '0;
    end else begin
      age_reg <= (age_reg == 2'h3) ? age_reg : age_reg + 2'h1;
      lvl_reg <= portb_level_o;
    end
  end
  assign evt = portb_int_en_i & ((portb_int_rise_i & portb_level_o & ~lvl_reg) |
                                 (~portb_int_rise_i & ~portb_level_o & lvl_reg));
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  a_levelb_sync: assert property (
    age_reg == 2'h3 |-> portb_level_o == $past(portb_pin_i, 2))
    else $error("port b level not two cycles behind pin");
  a_levelc_sync: assert property (
    age_reg == 2'h3 |-> portc_level_o == $past(portc_pin_i, 2))
    else $error("port c level not two cycles behind pin");
  a_input_no_drive: assert property (
    age_reg != 2'h0 |-> ($past(~portb_dir_i) & portb_pin_oe_o) == '0)
    else $error("input pin driven");
  a_int_set: assert property (
    age_reg == 2'h3 |=> (portb_int_flag_o & $past(evt)) == $past(evt))
    else $error("qualifying edge did not set flag");
  a_int_clear: assert property (
    age_reg == 2'h3 |=> (portb_int_flag_o & $past(portb_int_clr_i & ~evt)) == '0)
    else $error("flag survived clear");
  a_flag_cause: assert property (
    age_reg == 2'h3 |-> (portb_int_flag_o & ~$past(portb_int_flag_o) & ~$past(evt)) == '0)
    else $error("flag set without edge");
  a_uart_rx_path: assert property (
    age_reg == 2'h3 |-> uart_receive_line_o == $past(portc_pin_i[1], 2))
    else $error("receive line not pin one level");
  a_uart_tx_drive: assert property (
    (age_reg == 2'h3 && serial_mode_i == gpm_pkg::GPM_SER_UART &&
    portc_alt_sel_i[0] && $stable(uart_transmit_line_i))[*3] |->
    portc_pin_oe_o[0] && portc_pin_o[0] == uart_transmit_line_i)
    else $error("transmit data not on pin zero");
  a_i2c_release: assert property (
    (age_reg == 2'h3 && serial_mode_i == gpm_pkg::GPM_SER_I2C &&
    portc_alt_sel_i[0] && !i2c_clock_line_low_i)[*3] |-> !portc_pin_oe_o[0])
    else $error("I2C clock not released");
  c_flag: cover property (|portb_int_flag_o);
  c_i2c_low: cover property (serial_mode_i == gpm_pkg::GPM_SER_I2C && portc_pin_oe_o[0]);
  c_spi: cover property (serial_mode_i == gpm_pkg::GPM_SER_SPI && portc_alt_sel_i[2]);
endmodule
bind gpm_top gpm_top_sva #(.W(W)) gpm_top_sva_i (.*);

// ### bench/tb_top.sv
// Self-checking bench: random GPIO, interrupt and serial pin mux tests
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_top;
  logic [7:0] portb_pin_i, portb_pin_o, portb_pin_oe_o, portb_dir_i, portb_data_i, b_xen, b_xv;
  logic [7:0] portb_int_en_i, portb_int_rise_i, portb_int_clr_i, portb_level_o, portb_int_flag_o;
  logic [7:0] portc_pin_i, portc_pin_o, portc_pin_oe_o, portc_dir_i, portc_data_i, c_xen, c_xv;
  logic [7:0] portc_int_en_i, portc_int_rise_i, portc_int_clr_i, portc_level_o, portc_int_flag_o;
  logic [7:0] v, k;
  logic [2:0] portc_alt_sel_i, so, su;
  gpm_pkg::gpm_drive_t [7:0] portb_drive_i, portc_drive_i;
  gpm_pkg::gpm_ser_mode_t    serial_mode_i;
  logic clk_i, reset_n_i, spi_master_i, uart_transmit_line_i, uart_request_to_send_n_i;
  logic spi_slave_out_line_i, spi_master_out_line_i, spi_clock_line_i, i2c_clock_line_low_i;
  logic i2c_data_line_low_i, uart_receive_line_o, spi_slave_out_line_o, spi_master_out_line_o;
  logic spi_clock_line_o, i2c_clock_line_o, i2c_data_line_o;
  int   bad_count, n_compared;
  gpm_top gpm_top_i (.*);
  gpm_board gpm_board_b_i (.dev_val_i(portb_pin_o), .dev_en_i(portb_pin_oe_o), .ext_en_i(b_xen),
                           .ext_val_i(b_xv), .pad_o(portb_pin_i));
  gpm_board gpm_board_c_i (.dev_val_i(portc_pin_o), .dev_en_i(portc_pin_oe_o), .ext_en_i(c_xen),
                           .ext_val_i(c_xv), .pad_o(portc_pin_i));
  always #5 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [1:0] exp_drv(logic d, logic x, logic [1:0] m);
    case (m)
      2'h1: return {1'h0, d & ~x};
      2'h2: return {1'h1, d & x};
      default: return {x, d};
    endcase
  endfunction
  function automatic logic [7:0] pad(logic [7:0] oe, o, xe, xv);
    return (oe & o) | (~oe & (~xe | xv));
  endfunction
  task automatic tick(int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic chk_gpio(string n, logic [7:0] dir, dat, xe, xv, oe, o, lvl,
                          gpm_pkg::gpm_drive_t [7:0] drv);
    logic [7:0] eo, eu;
    for (int i = 0; i < 8; i++) {eu[i], eo[i]} = exp_drv(dir[i], dat[i], drv[i]);
    `CHK({n, " oe"}, eo, oe)
    `CHK({n, " out"}, eu, o)
    `CHK({n, " level"}, pad(eo, eu, xe, xv), lvl)
  endtask
  task automatic chk_flags(logic [7:0] e);
    `CHK("portb flag", e, portb_int_flag_o)
    `CHK("portc flag", e, portc_int_flag_o)
  endtask
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Tests need a few hundred cycles; 10000 leaves a wide margin
  initial begin
    #100000;
    bad_count++;
    final_report();
  end
  initial begin
    void'($urandom(31));
    {clk_i, reset_n_i, bad_count, n_compared} = '0;
    {portb_dir_i, portb_data_i, portb_int_en_i, portb_int_rise_i, portb_int_clr_i} = '0;
    {portc_dir_i, portc_data_i, portc_int_en_i, portc_int_rise_i, portc_int_clr_i} = '0;
    {b_xen, b_xv, c_xen, c_xv} = '0;
    {spi_master_i, uart_transmit_line_i, uart_request_to_send_n_i, spi_slave_out_line_i,
     spi_master_out_line_i, spi_clock_line_i, i2c_clock_line_low_i, i2c_data_line_low_i} = '0;
    portb_drive_i = {8{gpm_pkg::GPM_DRV_PUSH}};
    portc_drive_i = {8{gpm_pkg::GPM_DRV_PUSH}};
    serial_mode_i = gpm_pkg::GPM_SER_OFF;
    portc_alt_sel_i = 3'h0;
    tick(4);
    `CHK("reset state", 32'h0, {portb_pin_oe_o, portc_pin_oe_o, portb_level_o, portb_int_flag_o})
    reset_n_i = 1'h1;
    tick(2);
    repeat (16) begin
      {portb_dir_i, portb_data_i, portc_dir_i, portc_data_i} = 32'($urandom);
      {b_xv, c_xv, portc_alt_sel_i} = 19'($urandom);
      {b_xen, c_xen} = ~{portb_dir_i, portc_dir_i};
      for (int i = 0; i < 8; i++) begin
        portb_drive_i[i] = gpm_pkg::gpm_drive_t'(2'($urandom));
        portc_drive_i[i] = gpm_pkg::gpm_drive_t'(2'($urandom));
      end
      tick(4);
      chk_gpio("portb", portb_dir_i, portb_data_i, b_xen, b_xv, portb_pin_oe_o, portb_pin_o,
               portb_level_o, portb_drive_i);
      chk_gpio("portc", portc_dir_i, portc_data_i, c_xen, c_xv, portc_pin_oe_o, portc_pin_o,
               portc_level_o, portc_drive_i);
    end
    $display("gpio test done");
    {portb_dir_i, portc_dir_i, b_xv, c_xv} = '0;
    {b_xen, c_xen} = 16'hFFFF;
    for (int r = 0; r < 8; r++) begin
      {portb_int_en_i, portb_int_rise_i} = 16'($urandom);
      {portc_int_en_i, portc_int_rise_i} = {portb_int_en_i, portb_int_rise_i};
      {portb_int_clr_i, portc_int_clr_i} = 16'hFFFF;
      // Shared pins settle a cycle later, so the clear must outlast their last edge
      tick(6);
      {portb_int_clr_i, portc_int_clr_i} = '0;
      v = (r == 0) ? 8'hFF : 8'($urandom);
      {b_xv, c_xv} = {v, v};
      tick(5);
      chk_flags(v & portb_int_en_i & portb_int_rise_i);
      {b_xv, c_xv} = '0;
      tick(5);
      chk_flags(v & portb_int_en_i);
      k = 8'($urandom);
      {portb_int_clr_i, portc_int_clr_i} = {k, k};
      tick(1);
      {portb_int_clr_i, portc_int_clr_i} = '0;
      tick(1);
      chk_flags(v & portb_int_en_i & ~k);
    end
    $display("interrupt test done");
    for (int i = 0; i < 16; i++) begin
      portc_alt_sel_i = (i < 8) ? 3'h7 : 3'($urandom);
      serial_mode_i = gpm_pkg::gpm_ser_mode_t'(i[2:1]);
      spi_master_i = i[0];
      {uart_transmit_line_i, uart_request_to_send_n_i, spi_slave_out_line_i, spi_master_out_line_i,
       spi_clock_line_i, i2c_clock_line_low_i, i2c_data_line_low_i} = 7'($urandom);
      case (serial_mode_i)
        gpm_pkg::GPM_SER_UART:
          {so, su} = {3'h5, uart_request_to_send_n_i, 1'h0, uart_transmit_line_i};
        gpm_pkg::GPM_SER_SPI:
          {so, su} = spi_master_i ? {3'h6, spi_clock_line_i, spi_master_out_line_i, 1'h0}
                                  : {3'h1, 2'h0, spi_slave_out_line_i};
        gpm_pkg::GPM_SER_I2C:
          {so, su} = {1'h0, i2c_data_line_low_i, i2c_clock_line_low_i, 3'h0};
        default: {so, su} = 6'h00;
      endcase
      // Pins left on GPIO are inputs here, so they never drive
      so = so & portc_alt_sel_i;
      c_xen = {5'h00, ~so};
      c_xv = 8'($urandom);
      tick(4);
      `CHK("shared oe", so, portc_pin_oe_o[2:0])
      `CHK("shared out", su & so, portc_pin_o[2:0] & so)
      v = pad({5'h00, so}, {5'h00, su}, c_xen, c_xv);
      `CHK("serial in", {v[1], v[0], v[2], v[1], v[0], v[1]}, {i2c_data_line_o, i2c_clock_line_o,
           spi_clock_line_o, spi_master_out_line_o, spi_slave_out_line_o, uart_receive_line_o})
    end
    $display("serial test done");
    final_report();
  end
endmodule
